// ==== include/jpdr_pkg.sv ====
// constants for the programming data registers behind the boundary-scan port
//
// How it works
// - Code 0xC selects a one-bit reset chain; the TAP itself is never reset.
// - Internal reset follows a one in the chain directly, no output latch.
// - Chain one acts like reset pin low; a time-out holds reset after release.
// - Code 0x4 selects the 16-bit unlock register, filled during Shift-DR.
// - At Update-DR all 16 unlock bits must match the signature to enable.
// - Unlock register clears on power-on reset; programmer clears it on leaving.
// - Code 0x5 selects the 15-bit command register for serial commands.
// - Capture-DR loads the previous result; Shift-DR swaps it for the new command.
// - Update-DR applies the command; each Run-Test/Idle visit executes it once.
// - Code 0x6 selects the low eight command bits as page data byte.
// - Page load Update-DR copies the byte and writes the buffer within 11 TCK.
// - Page load alternates low then high byte, starting low after entry.
// - Page load pre-increments the word address before each low byte but the first.
// - Code 0x7 captures memory bytes, low then high, starting low after entry.
// - Page read increments the word address after every high byte.
// - Chip erase uses three fixed words, then polls the status bit.
// - Flash write entry word, then extended, high and low address loads.
// - Data low/high loads, latched by a three-word strobe sequence.
// - Flash page write uses a three-word trigger, then polls status.
// - Flash read entry word; three read words return low then high byte.
// - EEPROM write entry word; page write uses its own three-word trigger.
// - Every shift register moves its least significant bit first.
// - The instruction register is four bits, sixteen codes.
package jpdr_pkg;
  localparam int          IR_W           = 4;
  localparam int          CMD_W          = 15;
  localparam int          UNLOCK_W       = 16;
  localparam int          BYTE_W         = 8;
  localparam int          ADDR_W         = 24;
  localparam logic [3:0]  IR_RESET       = 4'hC;
  localparam logic [3:0]  IR_UNLOCK      = 4'h4;
  localparam logic [3:0]  IR_CMD         = 4'h5;
  localparam logic [3:0]  IR_FILL        = 4'h6;
  localparam logic [3:0]  IR_FETCH       = 4'h7;
  localparam logic [15:0] UNLOCK_SIG     = 16'hA370;
  localparam logic [15:0] UNLOCK_RST     = 16'h0000;
  localparam logic [14:0] CMD_RST        = 15'h0000;
  // upper seven command bits of the address and data loads
  localparam logic [6:0]  OP_ADR_EXT     = 7'h0B;
  localparam logic [6:0]  OP_ADR_HI      = 7'h07;
  localparam logic [6:0]  OP_ADR_LO      = 7'h03;
  localparam logic [6:0]  OP_DATA_LO     = 7'h13;
  localparam logic [6:0]  OP_DATA_HI     = 7'h17;
  localparam logic [14:0] CMD_ERASE_1    = 15'h2380;
  localparam logic [14:0] CMD_ERASE_2    = 15'h3180;
  localparam logic [14:0] CMD_ERASE_3    = 15'h3380;
  localparam logic [14:0] CMD_FLASH_WR   = 15'h2310;
  localparam logic [14:0] CMD_FLASH_RD   = 15'h2302;
  localparam logic [14:0] CMD_EE_WR      = 15'h2311;
  localparam logic [14:0] CMD_LATCH_2    = 15'h7700;
  localparam logic [14:0] CMD_PAGE_WR_2  = 15'h3500;
  localparam logic [14:0] CMD_PAGE_WR_3  = 15'h3700;
  localparam logic [14:0] CMD_EE_PG_2    = 15'h3100;
  localparam logic [14:0] CMD_RD_1       = 15'h3200;
  localparam logic [14:0] CMD_RD_2       = 15'h3600;
  localparam int          POLL_BIT       = 9;
  localparam int          RD_HI_BIT      = 8;
  localparam int          PAGE_WR_TCK    = 11;
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          RESET_TMO_NS   = 8192;
  localparam int          RESET_TMO_CYC  = (RESET_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] TMO_RST        = 16'h0000;
endpackage : jpdr_pkg

// ==== src/jpdr_top.sv ====
// programming data registers, command hand-off and page byte sequencing
`timescale 1ns/1ps
module jpdr_top #(
  parameter int TMO_CYC = jpdr_pkg::RESET_TMO_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          tck,
  input  wire logic                          tdi,
  input  wire logic [jpdr_pkg::IR_W-1:0]     tap_ir,
  input  wire logic                          tap_capture_dr,
  input  wire logic                          tap_shift_dr,
  input  wire logic                          tap_update_dr,
  input  wire logic                          tap_run_idle,
  output logic                               tdo_dr,
  output logic                               core_rst_n,
  output logic                               prog_mode,
  output logic [jpdr_pkg::CMD_W-1:0]         mem_cmd,
  output logic                               mem_exec,
  input  wire logic                          mem_busy,
  output logic [jpdr_pkg::ADDR_W-1:0]        rd_addr,
  input  wire logic [15:0]                   rd_word,
  output logic                               pb_wr,
  output logic                               pb_hi,
  output logic [jpdr_pkg::ADDR_W-1:0]        pb_addr,
  output logic [jpdr_pkg::BYTE_W-1:0]        pb_data
);
  import jpdr_pkg::*;

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = a + 24'h000001;
  endfunction : addr_inc

  ////////////////////////////////////////////////////////////////////////////
  // tck domain: data registers
  logic                 rst_chain_q;
  logic [UNLOCK_W-1:0]  unlock_sr_q;
  logic                 prog_en_q;
  logic [CMD_W-1:0]     cmd_sr_q;
  logic [CMD_W-1:0]     applied_q;
  logic                 exec_tog_q;
  logic                 run_idle_prev_q;
  logic                 ph_hi_q;
  logic                 ph_first_q;
  logic                 ev_tog_q;
  logic                 ev_load_q;
  logic                 ev_hi_q;
  logic                 ev_first_q;
  logic [BYTE_W-1:0]    ev_data_q;
  logic [CMD_W-1:0]     res_s1_q;
  logic [CMD_W-1:0]     res_s2_q;
  logic [15:0]          word_s1_q;
  logic [15:0]          word_s2_q;
  logic [CMD_W-1:0]     res_q;
  logic [15:0]          rd_word_q;
  logic                 page_ir;
  logic                 page_ev;

  assign page_ir = (tap_ir == IR_FILL) || (tap_ir == IR_FETCH);
  assign page_ev = prog_en_q && (((tap_ir == IR_FILL) && tap_update_dr) ||
                                 ((tap_ir == IR_FETCH) && tap_capture_dr));

  // reset chain only drives the core; nothing here touches the TAP controller
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      rst_chain_q <= 1'b0;
    end else if (tap_shift_dr && (tap_ir == IR_RESET)) begin
      rst_chain_q <= tdi;
    end
  end

  // unlock register, cleared only by power-on reset or by shifting zeros
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      unlock_sr_q <= UNLOCK_RST;
    end else if (tap_shift_dr && (tap_ir == IR_UNLOCK)) begin
      unlock_sr_q <= {tdi, unlock_sr_q[UNLOCK_W-1:1]};
    end
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      prog_en_q <= 1'b0;
    end else if (tap_update_dr && (tap_ir == IR_UNLOCK)) begin
      prog_en_q <= (unlock_sr_q == UNLOCK_SIG);
    end
  end

  // command register; page byte register is its low eight bits
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      cmd_sr_q <= CMD_RST;
    end else if (tap_capture_dr && (tap_ir == IR_CMD)) begin
      cmd_sr_q <= res_s2_q;
    end else if (tap_capture_dr && (tap_ir == IR_FETCH)) begin
      cmd_sr_q[BYTE_W-1:0] <= ph_hi_q ? word_s2_q[15:8] : word_s2_q[7:0];
    end else if (tap_shift_dr && (tap_ir == IR_CMD)) begin
      cmd_sr_q <= {tdi, cmd_sr_q[CMD_W-1:1]};
    end else if (tap_shift_dr && page_ir) begin
      cmd_sr_q[BYTE_W-1:0] <= {tdi, cmd_sr_q[BYTE_W-1:1]};
    end
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      applied_q <= CMD_RST;
    end else if (tap_update_dr && (tap_ir == IR_CMD)) begin
      applied_q <= cmd_sr_q;
    end
  end

  // one execute event per entry into Run-Test/Idle
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      run_idle_prev_q <= 1'b0;
      exec_tog_q      <= 1'b0;
    end else begin
      run_idle_prev_q <= tap_run_idle;
      if (tap_run_idle && !run_idle_prev_q && (tap_ir == IR_CMD) && prog_en_q) begin
        exec_tog_q <= ~exec_tog_q;
      end
    end
  end

  // byte phase restarts on low byte whenever a page instruction is entered from a non-page instruction
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      ph_hi_q    <= 1'b0;
      ph_first_q <= 1'b1;
    end else if (!page_ir) begin
      ph_hi_q    <= 1'b0;
      ph_first_q <= 1'b1;
    end else if (page_ev) begin
      ph_hi_q <= ~ph_hi_q;
      if (ph_hi_q) begin
        ph_first_q <= 1'b0;
      end
    end
  end

  // page event hand-off: fields held stable until the next toggle
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      ev_tog_q   <= 1'b0;
      ev_load_q  <= 1'b0;
      ev_hi_q    <= 1'b0;
      ev_first_q <= 1'b0;
      ev_data_q  <= 8'h00;
    end else if (page_ev) begin
      ev_tog_q   <= ~ev_tog_q;
      ev_load_q  <= (tap_ir == IR_FILL);
      ev_hi_q    <= ph_hi_q;
      ev_first_q <= ph_first_q;
      ev_data_q  <= cmd_sr_q[BYTE_W-1:0];
    end
  end

  // quasi-static words from the clk side, stable long before any capture
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      res_s1_q  <= CMD_RST;
      res_s2_q  <= CMD_RST;
      word_s1_q <= 16'h0000;
      word_s2_q <= 16'h0000;
    end else begin
      res_s1_q  <= res_q;
      res_s2_q  <= res_s1_q;
      word_s1_q <= rd_word_q;
      word_s2_q <= word_s1_q;
    end
  end

  always_comb begin
    unique case (tap_ir)
      IR_RESET:           tdo_dr = rst_chain_q;
      IR_UNLOCK:          tdo_dr = unlock_sr_q[0];
      IR_CMD:             tdo_dr = cmd_sr_q[0];
      IR_FILL, IR_FETCH:  tdo_dr = cmd_sr_q[0];
      default:            tdo_dr = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // clk domain: synchronisers
  logic                 chain_s1_q;
  logic                 chain_s2_q;
  logic                 prog_s1_q;
  logic                 prog_s2_q;
  logic [2:0]           exec_sync_q;
  logic [2:0]           ev_sync_q;
  logic                 exec_go;
  logic                 ev_go;
  logic [15:0]          tmo_cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chain_s1_q  <= 1'b0;
      chain_s2_q  <= 1'b0;
      prog_s1_q   <= 1'b0;
      prog_s2_q   <= 1'b0;
      exec_sync_q <= 3'h0;
      ev_sync_q   <= 3'h0;
    end else begin
      chain_s1_q  <= rst_chain_q;
      chain_s2_q  <= chain_s1_q;
      prog_s1_q   <= prog_en_q;
      prog_s2_q   <= prog_s1_q;
      exec_sync_q <= {exec_sync_q[1:0], exec_tog_q};
      ev_sync_q   <= {ev_sync_q[1:0], ev_tog_q};
    end
  end

  assign exec_go   = exec_sync_q[2] ^ exec_sync_q[1];
  assign ev_go     = ev_sync_q[2] ^ ev_sync_q[1];
  assign prog_mode = prog_s2_q;

  // reset time-out after the chain is released
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmo_cnt_q <= TMO_RST;
    end else if (chain_s2_q) begin
      tmo_cnt_q <= 16'(TMO_CYC);
    end else if (tmo_cnt_q != 16'h0000) begin
      tmo_cnt_q <= tmo_cnt_q - 16'h0001;
    end
  end

  // chain bit reaches the core with no latch in between
  assign core_rst_n = ~(rst_chain_q | chain_s2_q | (tmo_cnt_q != 16'h0000));

  ////////////////////////////////////////////////////////////////////////////
  // clk domain: command execution and word address
  logic [CMD_W-1:0]     mem_cmd_q;
  logic                 mem_exec_q;
  logic [ADDR_W-1:0]    addr_q;
  logic                 pb_wr_q;
  logic                 pb_hi_q;
  logic [ADDR_W-1:0]    pb_addr_q;
  logic [BYTE_W-1:0]    pb_data_q;
  logic [6:0]           op;

  assign op = applied_q[CMD_W-1:BYTE_W];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_cmd_q  <= CMD_RST;
      mem_exec_q <= 1'b0;
    end else begin
      mem_exec_q <= exec_go && prog_s2_q;
      if (exec_go) begin
        mem_cmd_q <= applied_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 24'h000000;
    end else if (exec_go && (op == OP_ADR_EXT)) begin
      addr_q[23:16] <= applied_q[BYTE_W-1:0];
    end else if (exec_go && (op == OP_ADR_HI)) begin
      addr_q[15:8] <= applied_q[BYTE_W-1:0];
    end else if (exec_go && (op == OP_ADR_LO)) begin
      addr_q[7:0] <= applied_q[BYTE_W-1:0];
    end else if (ev_go && ev_load_q && !ev_hi_q && !ev_first_q) begin
      addr_q <= addr_inc(addr_q);
    end else if (ev_go && !ev_load_q && ev_hi_q) begin
      addr_q <= addr_inc(addr_q);
    end
  end

  // result word: ready flag and the byte chosen by bit 8 of the last executed command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_q     <= CMD_RST;
      rd_word_q <= 16'h0000;
    end else begin
      rd_word_q       <= rd_word;
      res_q           <= CMD_RST;
      res_q[POLL_BIT] <= ~mem_busy;
      res_q[BYTE_W-1:0] <= mem_cmd_q[RD_HI_BIT] ? rd_word[15:8] : rd_word[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pb_wr_q   <= 1'b0;
      pb_hi_q   <= 1'b0;
      pb_addr_q <= 24'h000000;
      pb_data_q <= 8'h00;
    end else begin
      pb_wr_q <= ev_go && ev_load_q;
      if (ev_go && ev_load_q) begin
        pb_hi_q   <= ev_hi_q;
        pb_data_q <= ev_data_q;
        pb_addr_q <= (!ev_hi_q && !ev_first_q) ? addr_inc(addr_q) : addr_q;
      end
    end
  end

  assign mem_cmd  = mem_cmd_q;
  assign mem_exec = mem_exec_q;
  assign rd_addr  = addr_q;
  assign pb_wr    = pb_wr_q;
  assign pb_hi    = pb_hi_q;
  assign pb_addr  = pb_addr_q;
  assign pb_data  = pb_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_chain_reset;
    @(posedge tck) disable iff (!rstn) rst_chain_q |-> !core_rst_n;
  endproperty
  a_chain_reset: assert property (p_chain_reset) else $error("reset chain one without core reset");

  property p_unlock;
    @(posedge tck) disable iff (!rstn)
      (tap_update_dr && (tap_ir == IR_UNLOCK)) |=> (prog_en_q == ($past(unlock_sr_q) == UNLOCK_SIG));
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock result does not match signature compare");

  property p_cmd_shift;
    @(posedge tck) disable iff (!rstn)
      (tap_shift_dr && (tap_ir == IR_CMD) && !tap_capture_dr) |=>
        (cmd_sr_q[CMD_W-1] == $past(tdi)) && (cmd_sr_q[CMD_W-2:0] == $past(cmd_sr_q[CMD_W-1:1]));
  endproperty
  a_cmd_shift: assert property (p_cmd_shift) else $error("command register not shifting lsb first");

  property p_cmd_capture;
    @(posedge tck) disable iff (!rstn)
      (tap_capture_dr && (tap_ir == IR_CMD)) |=> (cmd_sr_q == $past(res_s2_q));
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) else $error("capture did not load previous result");

  property p_fill_write;
    @(posedge clk) disable iff (!rstn)
      ($changed(ev_tog_q) && prog_s2_q && (tap_ir == IR_FILL)) |-> ##[1:80] pb_wr;
  endproperty
  a_fill_write: assert property (p_fill_write) else $error("page buffer write later than allowed");

  property p_phase_alt;
    @(posedge tck) disable iff (!rstn)
      (page_ev && page_ir) ##1 page_ir |-> (ph_hi_q != $past(ph_hi_q));
  endproperty
  a_phase_alt: assert property (p_phase_alt) else $error("byte phase did not alternate");

  property p_phase_entry;
    @(posedge tck) disable iff (!rstn) !page_ir |=> (!ph_hi_q && ph_first_q);
  endproperty
  a_phase_entry: assert property (p_phase_entry) else $error("byte phase not restarted on entry");

  property p_load_inc;
    @(posedge clk) disable iff (!rstn)
      (ev_go && ev_load_q && !ev_hi_q && !ev_first_q && !exec_go) |=> (addr_q == addr_inc($past(addr_q)));
  endproperty
  a_load_inc: assert property (p_load_inc) else $error("no pre-increment before low byte");

  property p_load_first;
    @(posedge clk) disable iff (!rstn)
      (ev_go && ev_load_q && ev_first_q && !exec_go) |=> (pb_addr_q == $past(addr_q)) && $stable(addr_q);
  endproperty
  a_load_first: assert property (p_load_first) else $error("first page byte not at preset address");

  property p_read_inc;
    @(posedge clk) disable iff (!rstn)
      (ev_go && !ev_load_q && ev_hi_q && !exec_go) |=> (addr_q == addr_inc($past(addr_q)));
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("no post-increment after high byte");

  property p_tmo_hold;
    @(posedge clk) disable iff (!rstn) $fell(chain_s2_q) |-> !core_rst_n [*8];
  endproperty
  a_tmo_hold: assert property (p_tmo_hold) else $error("reset released without time-out");

endmodule : jpdr_top

// ==== tb/jpdr_prog_model.sv ====
// programmer model driving the boundary-scan data register states
`timescale 1ns/1ps
module jpdr_prog_model (
  output logic       tck,
  output logic       tdi,
  output logic [3:0] tap_ir,
  output logic       cap,
  output logic       sh,
  output logic       upd,
  output logic       ri,
  input  wire logic  tdo
);
  initial begin
    tck = 1'b1;
    tdi = 1'b0;
    tap_ir = 4'hF;
    {cap, sh, upd, ri} = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one tck period, states change just after the rising edge
  task automatic cyc(input logic [3:0] st, input logic d);
    {cap, sh, upd, ri} = st;
    tdi = d;
    #31 tck = 1'b0;
    #32 tck = 1'b1;
    #1;
  endtask : cyc
  // tck stands still outside frames; idle cycles let the quasi-static results settle
  task automatic scan(input logic [3:0] ir, input logic [15:0] din, input int n, input logic idle,
                      output logic [15:0] dout);
    tap_ir = ir;
    dout = 16'h0000;
    repeat (3) cyc(4'h0, ~tdi);
    cyc(4'h8, ~tdi);
    for (int i = 0; i < n; i++) begin
      dout[i] = tdo;
      cyc(4'h4, din[i]);
    end
    cyc(4'h2, ~tdi);
    if (idle) repeat (4) cyc(4'h1, ~tdi);
    {cap, sh, upd, ri} = 4'h0;
    tdi = ~tdi;
  endtask : scan
endmodule : jpdr_prog_model

// ==== tb/jpdr_top_tb.sv ====
// self-checking bench for the programming data registers
`timescale 1ns/1ps
module jpdr_top_tb;
  import jpdr_pkg::*;
  localparam int TMO = 32;
  logic              clk, rstn, tck, tdi, cap, sh, upd, ri, tdo_dr, core_rst_n, prog_mode;
  logic              mem_exec, mem_busy, pb_wr, pb_hi;
  logic [IR_W-1:0]   tap_ir;
  logic [CMD_W-1:0]  mem_cmd;
  logic [ADDR_W-1:0] rd_addr, pb_addr;
  logic [BYTE_W-1:0] pb_data, a;
  logic [15:0]       rd_word, dout;
  logic [32:0]       pb_q[$];
  int                bad_count = 0, cmp_count = 0, n_exec = 0, e0;
  logic [14:0]       seq [17] = '{CMD_FLASH_WR, {OP_ADR_EXT, 8'h01}, {OP_ADR_HI, 8'h02}, {OP_ADR_LO, 8'h03},
    {OP_DATA_LO, 8'h11}, {OP_DATA_HI, 8'h22}, CMD_PAGE_WR_3, CMD_LATCH_2, CMD_PAGE_WR_3, CMD_PAGE_WR_2,
    CMD_PAGE_WR_3, CMD_FLASH_RD, CMD_RD_1, CMD_RD_2, CMD_EE_WR, CMD_EE_PG_2, CMD_ERASE_3};
  // memory word follows the address so every byte read is predictable
  assign rd_word = {rd_addr[7:0] ^ 8'hA5, rd_addr[7:0]};
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (mem_exec === 1'b1) n_exec++;
    if (pb_wr === 1'b1) pb_q.push_back({pb_hi, pb_addr, pb_data});
  end
  jpdr_prog_model prog_u (.tck(tck), .tdi(tdi), .tap_ir(tap_ir), .cap(cap), .sh(sh), .upd(upd), .ri(ri),
    .tdo(tdo_dr));
  jpdr_top #(.TMO_CYC(TMO)) dut_u (.clk(clk), .rstn(rstn), .tck(tck), .tdi(tdi), .tap_ir(tap_ir),
    .tap_capture_dr(cap), .tap_shift_dr(sh), .tap_update_dr(upd), .tap_run_idle(ri), .tdo_dr(tdo_dr),
    .core_rst_n(core_rst_n), .prog_mode(prog_mode), .mem_cmd(mem_cmd), .mem_exec(mem_exec),
    .mem_busy(mem_busy), .rd_addr(rd_addr), .rd_word(rd_word), .pb_wr(pb_wr), .pb_hi(pb_hi),
    .pb_addr(pb_addr), .pb_data(pb_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : clks
  task automatic cmd(input logic [14:0] c);
    prog_u.scan(IR_CMD, {1'b0, c}, CMD_W, 1'b1, dout);
  endtask : cmd
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    mem_busy = 1'b1;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    clks(4);
    check(core_rst_n, 1'b1);
    check(prog_mode, 1'b0);
    // reset chain asserted before any unlock attempt
    prog_u.scan(IR_RESET, 16'h0001, 1, 1'b0, dout);
    check(core_rst_n, 1'b0);
    prog_u.scan(IR_RESET, 16'h0000, 1, 1'b0, dout);
    check(dout[0], 1'b1);
    clks(4);
    check(core_rst_n, 1'b0);
    clks(TMO + 8);
    check(core_rst_n, 1'b1);
    prog_u.scan(4'h1, 16'h00FF, 8, 1'b0, dout);
    check(dout, 16'h0000);
    // commands are refused while locked
    cmd(CMD_ERASE_1);
    check(24'(n_exec), 24'd0);
    prog_u.scan(IR_UNLOCK, 16'hA371, UNLOCK_W, 1'b0, dout);
    check(dout, 16'h0000);
    clks(4);
    check(prog_mode, 1'b0);
    prog_u.scan(IR_UNLOCK, UNLOCK_SIG, UNLOCK_W, 1'b0, dout);
    check(dout, 16'hA371);
    clks(4);
    check(prog_mode, 1'b1);
    // chip erase with busy then done status
    cmd(CMD_ERASE_1);
    cmd(CMD_ERASE_2);
    cmd(CMD_ERASE_3);
    check(mem_cmd, CMD_ERASE_3);
    cmd(CMD_ERASE_3);
    check(dout[14:0], 15'h00A5);
    clks(1);
    mem_busy = 1'b0;
    clks(2);
    cmd(CMD_ERASE_3);
    check(dout[14:0], 15'h02A5);
    // every command word of the write, read and eeprom sequences
    for (int i = 0; i < 17; i++) begin
      e0 = n_exec;
      cmd(seq[i]);
      check(24'(n_exec - e0), 24'd1);
      check(mem_cmd, seq[i]);
      if (i == 3) check(rd_addr, 24'h010203);
    end
    cmd({OP_ADR_LO, 8'h03});
    // page load alternates bytes and pre-increments the word address
    for (int i = 0; i < 3; i++) begin
      prog_u.scan(IR_FILL, {8'h00, 8'(8'h11 * (i + 1))}, BYTE_W, 1'b0, dout);
      #(PAGE_WR_TCK * 64);
      check(24'(pb_q.size()), 24'(i + 1));
    end
    for (int i = 0; i < 3; i++) begin
      check(pb_q[i][32], 24'(i % 2));
      check(pb_q[i][31:8], 24'h010203 + 24'(i / 2));
      check(pb_q[i][7:0], 24'(8'h11 * (i + 1)));
    end
    // page read captures low then high and post-increments
    cmd({OP_ADR_LO, 8'h10});
    for (int i = 0; i < 4; i++) begin
      prog_u.scan(IR_FETCH, 16'h0000, BYTE_W, 1'b0, dout);
      a = 8'h10 + 8'(i / 2);
      check(dout[7:0], (i % 2) ? (a ^ 8'hA5) : a);
    end
    clks(8);
    check(rd_addr, 24'h010212);
    // programmer clears the unlock register when leaving programming mode
    prog_u.scan(IR_UNLOCK, UNLOCK_RST, UNLOCK_W, 1'b0, dout);
    check(dout, UNLOCK_SIG);
    clks(4);
    check(prog_mode, 1'b0);
    finish_test();
  end
endmodule : jpdr_top_tb
